// ==== hw/rsc_reset_classifier.v ====
// reset source classifier top
`timescale 1ns/100ps
`default_nettype none
`include "rsc_defines.vh"
// What this block does
// [RULE1] classify each reset as one of six causes
// [RULE2] retained registers never get a reset pulse
// [RULE3] por, clear run/sleep and watchdog run reset the normal registers
// [RULE4] watchdog wake from sleep resets nothing
// [RULE5] timeout and powerdown bits form a cause-specific pattern
// [RULE6] short low glitches on the clear pin are ignored
// [RULE7] unimplemented status bits always read zero
// [RULE8] powerdown bit set on power-up, cleared by sleep
// [RULE9] timeout bit cleared on watchdog wake from sleep
// [RULE10] watchdog expiry resets while running, only wakes in sleep
// [RULE11] clear filter minimum width is a parameter in sample clocks
module rsc_reset_classifier #(
  parameter [7:0] FILT_MIN = `RSC_FILT_MIN,
  parameter [7:0] POR_HOLD = `RSC_POR_HOLD
) (
  input wire clk,
  input wire sys_rst,
  input wire external_clear_pin_n,
  input wire brownout_in,
  input wire watchdog_expire,
  input wire sleep_exec,
  input wire clrwdt_exec,
  output reg [2:0] cause_r,
  output reg cause_valid_r,
  output reg core_reset_r,
  output reg wake_r,
  output reg [7:0] status_flags_r
);
  localparam ST_RUN = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_HOLD = 2'h2;

  wire clr_pulse;
  reg bo1_r;
  reg bo2_r;
  reg por_done_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] hold_r;
  reg [7:0] hold_nxt;
  reg to_r;
  reg to_nxt;
  reg pd_r;
  reg pd_nxt;
  reg [2:0] cause_nxt;
  reg cause_valid_nxt;
  reg core_reset_nxt;
  reg wake_nxt;
  reg [2:0] event_cause;

  rsc_clear_filter #(.MIN_WIDTH(FILT_MIN)) u_filt (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_n(external_clear_pin_n),
    .clear_pulse(clr_pulse)
  );

  // event priority: brownout, clear, watchdog
  function [2:0] pick_cause;
    input in_sleep;
    input bo;
    input clr;
    input wd;
    begin
      if (bo) begin
        pick_cause = `RSC_CAUSE_BROWNOUT;
      end else if (clr) begin
        pick_cause = in_sleep ? `RSC_CAUSE_CLR_SLEEP : `RSC_CAUSE_CLR_RUN;
      end else if (wd) begin
        pick_cause = in_sleep ? `RSC_CAUSE_WDOG_WAKE : `RSC_CAUSE_WDOG_RUN;
      end else begin
        pick_cause = `RSC_CAUSE_NONE;
      end
    end
  endfunction

  // all causes but a watchdog wake reload normal registers
  function resets_core;
    input [2:0] cause;
    begin
      resets_core = (cause != `RSC_CAUSE_NONE) && (cause != `RSC_CAUSE_WDOG_WAKE);
    end
  endfunction

  // timeout bit after a cause
  function next_to;
    input [2:0] cause;
    input to_now;
    begin
      if (cause == `RSC_CAUSE_WDOG_RUN || cause == `RSC_CAUSE_WDOG_WAKE) begin
        next_to = 1'b0;
      end else if (cause == `RSC_CAUSE_BROWNOUT || cause == `RSC_CAUSE_POR) begin
        next_to = 1'b1;
      end else begin
        next_to = to_now;
      end
    end
  endfunction

  // powerdown bit after a cause; clear and wake keep it
  function next_pd;
    input [2:0] cause;
    input pd_now;
    begin
      if (cause == `RSC_CAUSE_WDOG_RUN || cause == `RSC_CAUSE_BROWNOUT ||
          cause == `RSC_CAUSE_POR) begin
        next_pd = 1'b1;
      end else begin
        next_pd = pd_now;
      end
    end
  endfunction

  // bits 7..5 and 2..0 unimplemented, read zero
  function [7:0] status_word;
    input to_bit;
    input pd_bit;
    begin
      status_word = {3'b000, to_bit, pd_bit, 3'b000}; // RULE7
    end
  endfunction

  // brownout level synchroniser
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bo1_r <= 1'b0;
      bo2_r <= 1'b0;
    end else begin
      bo1_r <= brownout_in;
      bo2_r <= bo1_r;
    end
  end

  // next state, cause and status bits
  always @* begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    to_nxt = to_r;
    pd_nxt = pd_r;
    cause_nxt = cause_r;
    cause_valid_nxt = 1'b0;
    core_reset_nxt = core_reset_r;
    wake_nxt = 1'b0;
    event_cause = `RSC_CAUSE_NONE;
    case (state_r)
      ST_HOLD: begin
        core_reset_nxt = 1'b1; // RULE3
        if (hold_r + 8'h01 >= POR_HOLD) begin
          hold_nxt = 8'h00;
          state_nxt = ST_RUN;
          core_reset_nxt = 1'b0;
        end else begin
          hold_nxt = hold_r + 8'h01;
        end
      end
      ST_RUN: begin
        event_cause = pick_cause(1'b0, bo2_r, clr_pulse, watchdog_expire); // RULE1
        if (event_cause == `RSC_CAUSE_NONE) begin
          if (sleep_exec) begin
            pd_nxt = 1'b0; // RULE8
            to_nxt = 1'b1;
            state_nxt = ST_SLEEP;
          end else if (clrwdt_exec) begin
            to_nxt = 1'b1;
            pd_nxt = 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        event_cause = pick_cause(1'b1, bo2_r, clr_pulse, watchdog_expire); // RULE1
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
    if (event_cause != `RSC_CAUSE_NONE) begin
      cause_nxt = event_cause;
      cause_valid_nxt = 1'b1;
      to_nxt = next_to(event_cause, to_r); // RULE5 RULE9
      pd_nxt = next_pd(event_cause, pd_r); // RULE5
      if (resets_core(event_cause)) begin
        state_nxt = ST_HOLD; // RULE10
        core_reset_nxt = 1'b1; // RULE3
      end else begin
        state_nxt = ST_RUN; // RULE4
        wake_nxt = 1'b1; // RULE10
      end
    end
    if (!por_done_r) begin
      cause_valid_nxt = 1'b1; // RULE1
    end
  end

  // state and output registers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_done_r <= 1'b0;
      state_r <= ST_HOLD;
      hold_r <= 8'h00;
      to_r <= 1'b1;
      pd_r <= 1'b1;
      cause_r <= `RSC_CAUSE_POR;
      cause_valid_r <= 1'b0;
      core_reset_r <= 1'b1;
      wake_r <= 1'b0;
      status_flags_r <= `RSC_STATUS_RST;
    end else begin
      por_done_r <= 1'b1;
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      to_r <= to_nxt;
      pd_r <= pd_nxt;
      cause_r <= cause_nxt;
      cause_valid_r <= cause_valid_nxt;
      core_reset_r <= core_reset_nxt;
      wake_r <= wake_nxt;
      status_flags_r <= status_word(to_r, pd_r); // RULE7
    end
  end

  // retained registers: no reset output exists for them at all
  // RULE2
endmodule
`default_nettype wire

// ==== hw/rsc_defines.vh ====
// constants for the reset source classifier
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH
`define RSC_CAUSE_NONE 3'h0
`define RSC_CAUSE_POR 3'h1
`define RSC_CAUSE_CLR_RUN 3'h2
`define RSC_CAUSE_CLR_SLEEP 3'h3
`define RSC_CAUSE_WDOG_RUN 3'h4
`define RSC_CAUSE_WDOG_WAKE 3'h5
`define RSC_CAUSE_BROWNOUT 3'h6
`define RSC_FILT_MIN 8'h04
`define RSC_POR_HOLD 8'h10
`define RSC_STATUS_RST 8'h18
`endif

// ==== hw/rsc_clear_filter.v ====
// glitch filter for the external clear pin
`timescale 1ns/100ps
`default_nettype none
`include "rsc_defines.vh"
module rsc_clear_filter #(
  parameter [7:0] MIN_WIDTH = `RSC_FILT_MIN
) (
  input wire clk,
  input wire sys_rst,
  input wire pin_n,
  output reg clear_pulse
);
  reg sync1_r;
  reg sync2_r;
  reg [7:0] cnt_r;
  reg fired_r;
  // two-flop synchroniser then low-width counter
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      cnt_r <= 8'h00;
      fired_r <= 1'b0;
      clear_pulse <= 1'b0;
    end else begin
      sync1_r <= pin_n;
      sync2_r <= sync1_r;
      clear_pulse <= 1'b0;
      if (sync2_r) begin
        cnt_r <= 8'h00; // RULE6
        fired_r <= 1'b0;
      end else if (!fired_r) begin
        if (cnt_r + 8'h01 >= MIN_WIDTH) begin // RULE11
          fired_r <= 1'b1;
          clear_pulse <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/rsc_asserts.sv ====
// checker for the reset source classifier ports
`timescale 1ns/100ps
`default_nettype none
module rsc_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sleep_exec,
  input wire logic clrwdt_exec,
  input wire logic [2:0] cause_r,
  input wire logic cause_valid_r,
  input wire logic core_reset_r,
  input wire logic wake_r,
  input wire logic [7:0] status_flags_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_cause_in_range: assert property (
    cause_valid_r |-> cause_r inside {[1:6]}) else $error("cause out of range");
  a_reset_on_cause: assert property (
    cause_valid_r && cause_r != 5 |-> core_reset_r) else $error("missing core reset");
  a_wake_no_reset: assert property (
    cause_valid_r && cause_r == 5 |-> wake_r && !core_reset_r) else $error("bad wake");
  a_wake_clears_to: assert property (
    wake_r |=> !status_flags_r[4]) else $error("timeout bit kept on wake");
  a_unimpl_zero: assert property (
    (status_flags_r & 8'he7) == 0) else $error("unimplemented bit set");
  a_sleep_clears_pd: assert property (
    sleep_exec && !core_reset_r |-> ##2 !status_flags_r[3]) else $error("pd kept");
  a_clrwdt_sets: assert property (
    clrwdt_exec && !core_reset_r |-> ##2 status_flags_r[4:3] == 2'b11) else $error("bits");
  a_reset_hold: assert property (
    $rose(core_reset_r) |-> core_reset_r [*8]) else $error("core reset too short");
endmodule
bind rsc_reset_classifier rsc_asserts chk_u (.*);
`default_nettype wire

// ==== dv/rsc_far_side.sv ====
// model of clear pin, supply monitor and watchdog
`timescale 1ns/100ps
`default_nettype none
module rsc_far_side (
  input wire logic clk,
  output logic clr_n,
  output logic bout,
  output logic wdx
);
  initial begin
    clr_n = 1;
    bout = 0;
    wdx = 0;
  end
  task clr(input int n);
    @(posedge clk) clr_n <= 0;
    repeat (n) @(posedge clk);
    clr_n <= 1;
  endtask
  task bo(input int n);
    @(posedge clk) bout <= 1;
    repeat (n) @(posedge clk);
    bout <= 0;
  endtask
  task wd;
    @(posedge clk) wdx <= 1;
    @(posedge clk) wdx <= 0;
  endtask
endmodule
`default_nettype wire

// ==== dv/rsc_reset_classifier_tb.sv ====
// testbench for the reset source classifier
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_classifier_tb;
  logic clk, sys_rst, sleep_exec, clrwdt_exec;
  wire logic clr_n, bout, wdx, cause_valid_r, core_reset_r, wake_r;
  wire logic [2:0] cause_r;
  wire logic [7:0] status_flags_r;
  int n_errors = 0;
  int n_compared = 0;
  bit h;
  rsc_far_side fs (.clk(clk), .clr_n(clr_n), .bout(bout), .wdx(wdx));
  rsc_reset_classifier #(.FILT_MIN(8'h04), .POR_HOLD(8'h10)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .external_clear_pin_n(clr_n), .brownout_in(bout),
    .watchdog_expire(wdx), .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec),
    .cause_r(cause_r), .cause_valid_r(cause_valid_r), .core_reset_r(core_reset_r),
    .wake_r(wake_r), .status_flags_r(status_flags_r));
  task chk(input [7:0] g, input [7:0] e, input string s);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task grab;
    h = 0;
    for (int i = 0; i < 30 && !h; i++) begin
      #1;
      h = (cause_valid_r === 1'b1);
      if (!h) @(posedge clk);
    end
  endtask
  task see(input [2:0] c, input r, input [7:0] st);
    grab;
    chk(h, 1, "valid");
    chk(cause_r, c, "cause");
    chk(core_reset_r, r, "core reset");
    chk(wake_r, c == 5, "wake");
    @(posedge clk) #1 chk(status_flags_r, st, "status");
    for (int i = 0; i < 40 && core_reset_r !== 1'b0; i++) @(posedge clk) #1;
    chk(core_reset_r, 0, "reset release");
    $display("test cause %0d done", c);
  endtask
  task op(input bit s, input [7:0] st);
    @(posedge clk) {sleep_exec, clrwdt_exec} <= {s, !s};
    @(posedge clk) {sleep_exec, clrwdt_exec} <= 2'b00;
    repeat (3) @(posedge clk);
    #1 chk(status_flags_r, st, "status after op");
    $display("test op done");
  endtask
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    give_verdict;
  end
  initial begin
    {sys_rst, sleep_exec, clrwdt_exec} = 3'b100;
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    see(1, 1, 8'h18);
    fs.wd;
    see(4, 1, 8'h08);
    op(1, 8'h10);
    fs.wd;
    see(5, 0, 8'h00);
    op(1, 8'h10);
    fork
      fs.clr(10);
      see(3, 1, 8'h10);
    join
    fs.clr(3);
    grab;
    chk(h, 0, "glitch");
    fork
      fs.clr(10);
      see(2, 1, 8'h10);
    join
    op(0, 8'h18);
    fork
      fs.bo(4);
      see(6, 1, 8'h18);
    join
    give_verdict;
  end
endmodule
`default_nettype wire
